//--- acc_conv_ctrl.sv
// Converter control and status: enable, track modes, start sources, flags
`timescale 1ns/100ps
module acc_conv_ctrl #(
  parameter int CONV_SAR_CLKS = acc_pkg::CONV_SAR_CLKS,
  parameter int RES_W         = acc_pkg::RES_W
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [7:0]       sfr_addr,
  input  wire logic             sfr_wr,
  input  wire logic [7:0]       sfr_wdata,
  input  wire logic             sfr_bit_wr,
  input  wire logic [2:0]       sfr_bit_sel,
  input  wire logic             sfr_bit_val,
  output logic      [7:0]       sfr_rdata,
  input  wire logic             tmr0_ovf,
  input  wire logic             tmr2_ovf,
  input  wire logic             tmr3_ovf,
  input  wire logic             aux_start_a,
  input  wire logic             aux_start_b,
  input  wire logic [RES_W-1:0] sar_result,
  input  wire logic [RES_W-1:0] win_gt_limit,
  input  wire logic [RES_W-1:0] win_lt_limit,
  output logic                  conv_shutdown,
  output logic                  conv_tracking,
  output logic                  conv_start,
  output logic                  sar_clk_en,
  output logic                  conv_done,
  output logic      [RES_W-1:0] conv_result
);
  import acc_pkg::*;

  if (CONV_SAR_CLKS < 1 || CONV_SAR_CLKS > 255) begin : g_bad_conv_len
    $error("CONV_SAR_CLKS must be 1 to 255");
  end

  localparam logic [7:0] CONV_LAST  = 8'(CONV_SAR_CLKS - 1);
  localparam logic [7:0] DELAY_LAST = DELAY_SAR_CLKS - 8'h01;

  logic             conv_enable;
  logic             track_select;
  logic             conv_done_flag;
  logic             window_match_flag;
  logic [2:0]       start_source_select;
  logic [7:0]       cfg;
  acc_state_e       state;
  logic [DIV_W-1:0] div_cnt;
  logic [7:0]       ph_cnt;
  logic [7:0]       wmask;
  logic [7:0]       wval;
  logic             trig;
  logic             start_evt;
  logic             sar_tick;
  logic             finish;
  logic             conv_active;
  logic [DIV_W-1:0] sar_clock_divider;

  acc_win_if #(.RES_W(RES_W)) wif ();

  acc_window u_window (
    .core_clk (core_clk),
    .reset    (reset),
    .wif      (wif)
  );

  assign wif.result   = sar_result;
  assign wif.gt_limit = win_gt_limit;
  assign wif.lt_limit = win_lt_limit;
  assign wif.check    = finish;

  assign sar_clock_divider = cfg[DIV_LSB +: DIV_W];
  assign conv_active       = state != ACC_IDLE; // [RULE5]

  // Byte writes touch every bit, bit writes only the selected one
  always_comb begin
    wmask = 8'h00;
    wval  = 8'h00;
    if (sfr_wr && sfr_addr == CTRL_ADDR) begin
      wmask = 8'hFF;
      wval  = sfr_wdata;
    end else if (sfr_bit_wr && sfr_addr == CTRL_ADDR) begin
      wmask[sfr_bit_sel] = 1'b1;
      wval[sfr_bit_sel]  = sfr_bit_val;
    end
  end

  // Start source mux; reserved codes never trigger
  always_comb begin
    unique case (start_source_select)
      SRC_SW:    trig = wmask[ACTIVE_BIT] && wval[ACTIVE_BIT]; // [RULE6]
      SRC_T0:    trig = tmr0_ovf;    // [RULE8]
      SRC_T2:    trig = tmr2_ovf;    // [RULE8]
      SRC_AUX_A: trig = aux_start_a; // [RULE10]
      SRC_AUX_B: trig = aux_start_b; // [RULE10]
      SRC_T3:    trig = tmr3_ovf;    // [RULE9]
      default:   trig = 1'b0;        // [RULE9]
    endcase
  end

  // Starts taken only when enabled and idle; a start while busy is dropped
  assign start_evt = conv_enable && state == ACC_IDLE && trig; // [RULE1]
  assign sar_tick  = conv_active && div_cnt == sar_clock_divider;
  assign finish    = state == ACC_CONV && sar_tick && ph_cnt == CONV_LAST;

  // SAR clock divider, restarted on each start so the first period is full
  always_ff @(posedge core_clk) begin
    if (reset || !conv_enable || start_evt || div_cnt == sar_clock_divider) begin
      div_cnt <= '0; // [RULE11]
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Conversion sequencer
  always_ff @(posedge core_clk) begin
    if (reset || !conv_enable) begin
      state  <= ACC_IDLE; // [RULE1]
      ph_cnt <= 8'h00;
    end else begin
      unique case (state)
        ACC_IDLE: begin
          ph_cnt <= 8'h00;
          if (start_evt) begin
            state <= track_select ? ACC_DELAY : ACC_CONV; // [RULE2] [RULE3]
          end
        end
        ACC_DELAY: begin
          if (sar_tick) begin
            ph_cnt <= (ph_cnt == DELAY_LAST) ? 8'h00 : ph_cnt + 8'h01;
            if (ph_cnt == DELAY_LAST) begin
              state <= ACC_CONV; // [RULE3]
            end
          end
        end
        ACC_CONV: begin
          if (sar_tick) begin
            ph_cnt <= ph_cnt + 8'h01;
            if (finish) begin
              state <= ACC_IDLE;
            end
          end
        end
        default: state <= ACC_IDLE;
      endcase
    end
  end

  // Software fields of the control register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_enable         <= CTRL_RESET[EN_BIT];
      track_select        <= CTRL_RESET[TRACK_BIT];
      start_source_select <= CTRL_RESET[SRC_LSB +: SRC_W];
    end else begin
      if (wmask[EN_BIT]) conv_enable <= wval[EN_BIT];
      if (wmask[TRACK_BIT]) track_select <= wval[TRACK_BIT];
      for (int i = 0; i < SRC_W; i++) begin
        if (wmask[SRC_LSB + i]) start_source_select[i] <= wval[SRC_LSB + i];
      end
    end
  end

  // Sticky flags: a hardware set beats a same-cycle software clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_done_flag    <= CTRL_RESET[DONE_BIT];
      window_match_flag <= CTRL_RESET[WIN_BIT];
    end else begin
      if (finish) conv_done_flag <= 1'b1; // [RULE4]
      else if (wmask[DONE_BIT]) conv_done_flag <= wval[DONE_BIT];
      if (wif.match) window_match_flag <= 1'b1; // [RULE7]
      else if (wmask[WIN_BIT]) window_match_flag <= wval[WIN_BIT];
    end
  end

  // Configuration register; only the divider field steers logic here
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg <= CFG_RESET;
    end else if (sfr_wr && sfr_addr == CFG_ADDR) begin
      cfg <= sfr_wdata;
    end
  end

  // Registered read port, unmapped addresses read zero
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_addr == CTRL_ADDR) begin
      sfr_rdata <= {conv_enable, track_select, conv_done_flag, conv_active,
                    window_match_flag, start_source_select}; // [RULE5]
    end else if (sfr_addr == CFG_ADDR) begin
      sfr_rdata <= cfg;
    end else begin
      sfr_rdata <= 8'h00;
    end
  end

  // Core-facing controls, all registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_shutdown <= 1'b1;
      conv_tracking <= 1'b0;
      conv_start    <= 1'b0;
      sar_clk_en    <= 1'b0;
      conv_done     <= 1'b0;
      conv_result   <= '0;
    end else begin
      conv_shutdown <= !conv_enable; // [RULE1]
      conv_tracking <= conv_enable && state != ACC_CONV; // [RULE2]
      conv_start    <= (start_evt && !track_select) ||
                       (state == ACC_DELAY && sar_tick && ph_cnt == DELAY_LAST);
      sar_clk_en    <= sar_tick;
      conv_done     <= finish;
      if (finish) conv_result <= sar_result;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  AST_SHUTDOWN: assert property (!conv_enable |=> conv_shutdown && state == ACC_IDLE) // [RULE1]
    else $error("disabled converter not in shutdown");
  AST_NORMAL_START: assert property (start_evt && !track_select |=> state == ACC_CONV) // [RULE2]
    else $error("normal mode start did not convert at once");
  AST_DELAY_ENTRY: assert property (start_evt && track_select |=> state == ACC_DELAY) // [RULE3]
    else $error("delayed mode start skipped tracking");
  AST_DELAY_HOLD: assert property ( // [RULE3]
    (conv_enable && state == ACC_DELAY && sar_tick && ph_cnt < DELAY_LAST)
      |=> state == ACC_DELAY)
    else $error("delayed tracking ended early");
  AST_DONE_SET: assert property (finish |=> conv_done_flag && conv_done) // [RULE4]
    else $error("done flag not set on finish");
  AST_DONE_STICKY: assert property ( // [RULE4]
    conv_done_flag && !(wmask[DONE_BIT] && !wval[DONE_BIT]) |=> conv_done_flag)
    else $error("done flag dropped without a clear");
  AST_ACTIVE_READ: assert property ( // [RULE5]
    sfr_addr == CTRL_ADDR |=> sfr_rdata[ACTIVE_BIT] == $past(conv_active))
    else $error("active bit does not reflect conversion state");
  AST_SW_START: assert property ( // [RULE6]
    conv_enable && state == ACC_IDLE && wmask[ACTIVE_BIT] && wval[ACTIVE_BIT]
      && start_source_select == SRC_SW |=> state != ACC_IDLE)
    else $error("software start ignored");
  AST_WIN_STICKY: assert property ( // [RULE7]
    window_match_flag && !(wmask[WIN_BIT] && !wval[WIN_BIT]) |=> window_match_flag)
    else $error("window flag dropped without a clear");
  AST_T0_START: assert property ( // [RULE8]
    conv_enable && state == ACC_IDLE && start_source_select == SRC_T0 && tmr0_ovf
      |=> state != ACC_IDLE)
    else $error("timer 0 overflow did not start");
  AST_RESERVED: assert property ( // [RULE9]
    state == ACC_IDLE && start_source_select[2:1] == 2'b11 && !wmask[SRC_LSB + 1]
      |=> state == ACC_IDLE)
    else $error("reserved source started a conversion");
  AST_DIV_PERIOD: assert property ( // [RULE11]
    sar_tick && state == ACC_CONV && !finish && sar_clock_divider == 5'h01
      && !(wmask[EN_BIT] && !wval[EN_BIT])
      |=> !sar_tick ##1 sar_tick)
    else $error("SAR clock period wrong");

  COV_NORMAL: cover property (start_evt && !track_select ##[1:1000] finish);
  COV_DELAYED: cover property (start_evt && track_select ##[1:1000] finish);
  COV_WINDOW: cover property (wif.match ##1 window_match_flag);
endmodule

//--- acc_pkg.sv
// Constants, register layout and state encoding of the converter control block
// Operation
// RULE1 - Enable low: shutdown; enable high: accept starts
// RULE2 - Normal mode: track continuously, convert at once
// RULE3 - Delayed mode: three extra SAR clocks tracking first
// RULE4 - Done flag set on finish, sticky
// RULE5 - Active bit reads one while converting
// RULE6 - Writing active one starts only with source 000
// RULE7 - Window flag set on match, sticky
// RULE8 - Source 001 timer 0, 010 timer 2
// RULE9 - Source 101 timer 3; 11x starts nothing
// RULE10 - Sources 011, 100 take two auxiliary triggers
// RULE11 - SAR clock period is divider plus one
// RULE12 - Window compare inside or outside by limit order
package acc_pkg;
  localparam logic [7:0] CTRL_ADDR  = 8'hE8;
  localparam logic [7:0] CFG_ADDR   = 8'hBC;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'hF9;
  // Control register bit positions
  localparam int EN_BIT     = 7;
  localparam int TRACK_BIT  = 6;
  localparam int DONE_BIT   = 5;
  localparam int ACTIVE_BIT = 4;
  localparam int WIN_BIT    = 3;
  localparam int SRC_LSB    = 0;
  localparam int SRC_W      = 3;
  // Configuration register divider field
  localparam int DIV_LSB    = 3;
  localparam int DIV_W      = 5;
  // Start source codes
  localparam logic [2:0] SRC_SW    = 3'h0;
  localparam logic [2:0] SRC_T0    = 3'h1;
  localparam logic [2:0] SRC_T2    = 3'h2;
  localparam logic [2:0] SRC_AUX_A = 3'h3;
  localparam logic [2:0] SRC_AUX_B = 3'h4;
  localparam logic [2:0] SRC_T3    = 3'h5;
  // Timing in SAR clocks and result width
  localparam logic [7:0] DELAY_SAR_CLKS = 8'h03;
  localparam int         CONV_SAR_CLKS  = 11;
  localparam int         RES_W          = 10;
  typedef enum logic [1:0] {
    ACC_IDLE  = 2'b00,
    ACC_DELAY = 2'b01,
    ACC_CONV  = 2'b11
  } acc_state_e;
endpackage

//--- acc_win_if.sv
// Carrier between the control core and the window comparator
`timescale 1ns/100ps
interface acc_win_if #(parameter int RES_W = 10);
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] gt_limit;
  logic [RES_W-1:0] lt_limit;
  logic             check;
  logic             match;
  modport ctl (output result, output gt_limit, output lt_limit, output check, input match);
  modport win (input result, input gt_limit, input lt_limit, input check, output match);
endinterface

//--- acc_window.sv
// Window comparator: flags a result inside or outside the programmed limits
`timescale 1ns/100ps
module acc_window (
  input wire logic core_clk,
  input wire logic reset,
  acc_win_if.win   wif
);
  import acc_pkg::*;

  logic inside_mode;
  logic hit;

  // Ordering of the limits picks inside or outside detection
  always_comb begin
    inside_mode = wif.lt_limit > wif.gt_limit;
    if (inside_mode) begin
      hit = (wif.result > wif.gt_limit) && (wif.result < wif.lt_limit); // [RULE12]
    end else begin
      hit = (wif.result > wif.gt_limit) || (wif.result < wif.lt_limit); // [RULE12]
    end
  end

  // Registered one-cycle match pulse
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wif.match <= 1'b0;
    end else begin
      wif.match <= wif.check && hit;
    end
  end

  AST_WIN_INSIDE: assert property (@(posedge core_clk) disable iff (reset) // [RULE12]
    (wif.check && wif.lt_limit > wif.gt_limit && wif.result > wif.gt_limit
     && wif.result < wif.lt_limit) |=> wif.match)
    else $error("inside window result did not match");
  AST_WIN_NO_CHECK: assert property (@(posedge core_clk) disable iff (reset) // [RULE12]
    !wif.check |=> !wif.match)
    else $error("window match without a check");
endmodule

//--- acc_far_model.sv
// Far-side model: timer and auxiliary trigger pulses, SAR core result
`timescale 1ns/100ps
module acc_far_model (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [4:0] fire,
  input  wire logic [9:0] res_val,
  input  wire logic       conv_start,
  input  wire logic       conv_done,
  output logic            tmr0_ovf,
  output logic            tmr2_ovf,
  output logic            tmr3_ovf,
  output logic            aux_start_a,
  output logic            aux_start_b,
  output logic [9:0]      sar_result
);
  logic busy;
  // One-cycle timer overflow or auxiliary start pulse for each request bit
  always_ff @(posedge core_clk) begin
    {aux_start_b, aux_start_a, tmr3_ovf, tmr2_ovf, tmr0_ovf} <= reset ? 5'h00 : fire;
  end
  // Core converts from start until done
  always_ff @(posedge core_clk) begin
    if (reset || conv_done) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
    end
  end
  // Outside a conversion the result bus carries junk, not the last value
  assign sar_result = busy ? res_val : ~res_val;
endmodule

//--- acc_conv_ctrl_tb.sv
// Self-checking testbench of the converter control block
`timescale 1ns/100ps
module acc_conv_ctrl_tb;
  import acc_pkg::*;
  localparam int CN = 2;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
  logic       sfr_wr = 1'b0, sfr_bit_wr = 1'b0, sfr_bit_val = 1'b0;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic [4:0] fire = 5'h00;
  logic       tmr0_ovf, tmr2_ovf, tmr3_ovf, aux_start_a, aux_start_b;
  logic [9:0] res_val = 10'h155, sar_result, conv_result;
  logic [9:0] win_gt_limit = 10'h3FF, win_lt_limit = 10'h000;
  logic       conv_shutdown, conv_tracking, conv_start, sar_clk_en, conv_done;
  int         mismatches = 0;
  int         tests_run = 0;
  // Short conversion keeps the run brief
  acc_conv_ctrl #(.CONV_SAR_CLKS(CN)) uut (.core_clk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata,
    .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .tmr0_ovf, .tmr2_ovf, .tmr3_ovf,
    .aux_start_a, .aux_start_b, .sar_result, .win_gt_limit, .win_lt_limit, .conv_shutdown,
    .conv_tracking, .conv_start, .sar_clk_en, .conv_done, .conv_result);
  acc_far_model far (.core_clk, .reset, .fire, .res_val, .conv_start, .conv_done, .tmr0_ovf,
    .tmr2_ovf, .tmr3_ovf, .aux_start_a, .aux_start_b, .sar_result);
  // Clock at 125 MHz
  always #4 core_clk = ~core_clk;
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Register bus: byte write, bit write, read one cycle after address
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic bw(input logic [2:0] s, input logic v);
    @(posedge core_clk);
    sfr_addr <= CTRL_ADDR;
    sfr_bit_sel <= s;
    sfr_bit_val <= v;
    sfr_bit_wr <= 1'b1;
    @(posedge core_clk);
    sfr_bit_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    sfr_addr <= a;
    @(posedge core_clk);
    #1 chk(10'(sfr_rdata), 10'(exp));
  endtask
  task automatic pulse(input logic [4:0] m);
    @(posedge core_clk);
    fire <= m;
    @(posedge core_clk);
    fire <= 5'h00;
  endtask
  function automatic logic sel(input int w);
    return (w == 0) ? conv_start : (w == 1) ? conv_done : sar_clk_en;
  endfunction
  // Cycles until a pulse; an expected pulse that never comes ends the run
  task automatic wt(input int w, input int lim, input bit must, output int n);
    n = 0;
    #1;
    while (n < lim && sel(w) !== 1'b1) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (must && n == lim) begin
      chk(10'h001, 10'h000);
      close_out();
    end
  endtask
  task automatic t_reset;
    rd(CTRL_ADDR, CTRL_RESET);
    rd(CFG_ADDR, CFG_RESET);
    rd(8'h10, 8'h00);
    chk(10'(conv_shutdown), 10'h001);
  endtask
  task automatic t_normal;
    int n;
    wr(CFG_ADDR, 8'h08);
    wr(CTRL_ADDR, 8'h80);
    rd(CTRL_ADDR, 8'h80);
    chk(10'({conv_shutdown, conv_tracking}), 10'h001);
    bw(3'h4, 1'b1);
    wt(0, 8, 1'b1, n);
    chk(10'(n), 10'h000);
    wt(1, 40, 1'b1, n);
    chk(10'(n), 10'(CN * 2));
    chk(conv_result, res_val);
    rd(CTRL_ADDR, 8'hA0);
    rd(CTRL_ADDR, 8'hA0);
    bw(3'h5, 1'b0);
    rd(CTRL_ADDR, 8'h80);
  endtask
  task automatic t_swrule;
    int n;
    bw(3'h4, 1'b0);
    wt(0, 20, 1'b0, n);
    chk(10'(n), 10'h014);
    wr(CTRL_ADDR, 8'h81);
    bw(3'h4, 1'b1);
    wt(0, 20, 1'b0, n);
    chk(10'(n), 10'h014);
  endtask
  task automatic t_delay;
    int n;
    wr(CTRL_ADDR, 8'hC0);
    bw(3'h4, 1'b1);
    wt(0, 20, 1'b1, n);
    chk(10'(n), 10'h006);
    chk(10'(conv_tracking), 10'h001);
    wt(1, 40, 1'b1, n);
  endtask
  // Divider 4: SAR ticks five cycles apart, active bit high meanwhile
  task automatic t_clkdiv;
    int n;
    wr(CFG_ADDR, 8'h20);
    wr(CTRL_ADDR, 8'h80);
    bw(3'h4, 1'b1);
    wt(0, 8, 1'b1, n);
    rd(CTRL_ADDR, 8'h90);
    chk(10'(conv_tracking), 10'h000);
    @(posedge core_clk);
    wt(2, 20, 1'b1, n);
    @(posedge core_clk);
    wt(2, 20, 1'b1, n);
    chk(10'(n), 10'h004);
    wt(1, 60, 1'b1, n);
    wr(CFG_ADDR, 8'h08);
  endtask
  // Every source code against every trigger input
  task automatic t_sources;
    logic [4:0] tmask [8] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h10, 5'h04, 5'h00, 5'h00};
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(CTRL_ADDR, 8'h80 | 8'(c));
      for (int b = 0; b < 5; b++) begin
        pulse(5'h01 << b);
        wt(0, 6, 1'b0, n);
        chk(10'(n < 6), 10'(tmask[c][b]));
        if (n < 6) wt(1, 40, 1'b1, n);
      end
    end
  endtask
  // Inside hit, outside miss, outside hit for result 155
  task automatic t_window;
    logic [9:0] gt [3] = '{10'h100, 10'h200, 10'h100};
    logic [9:0] lt [3] = '{10'h200, 10'h100, 10'h080};
    logic [7:0] ex [3] = '{8'hA8, 8'hA0, 8'hA8};
    int n;
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      win_gt_limit <= gt[i];
      win_lt_limit <= lt[i];
      wr(CTRL_ADDR, 8'h80);
      bw(3'h4, 1'b1);
      wt(1, 40, 1'b1, n);
      rd(CTRL_ADDR, ex[i]);
    end
    bw(3'h3, 1'b0);
    rd(CTRL_ADDR, 8'hA0);
  endtask
  task automatic t_disabled;
    int n;
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h00);
    chk(10'(conv_shutdown), 10'h001);
    bw(3'h4, 1'b1);
    wt(0, 20, 1'b0, n);
    chk(10'(n), 10'h014);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_normal();
    t_swrule();
    t_delay();
    t_clkdiv();
    t_sources();
    t_window();
    t_disabled();
    close_out();
  end
endmodule
